// ===== verif/clock_sync_properties.sv
// Purpose: Concurrent checks on the sync, enable and register bus ports
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every instance of the sync block
`default_nettype none
module clock_sync_properties #(
    parameter int unsigned NUM_OUT = 8
) (
    input wire logic                    i_sys_clk,        // System clock
    input wire logic                    i_reset,          // Synchronous reset
    input wire logic                    i_sync_request_n, // Sync pin, active low
    input wire logic                    i_primary_clk,    // Bypass source 0
    input wire logic                    i_secondary_clk,  // Bypass source 1
    input wire clk_sync_pkg::axil_req_s i_axil,           // Bus requests
    input wire clk_sync_pkg::axil_rsp_s o_axil,           // Bus responses
    input wire logic [NUM_OUT-1:0]      o_clk_out,        // Clock levels
    input wire logic [NUM_OUT-1:0]      o_clk_oe_n        // Enables, low drives
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    chk_reset_quiet: assert property (@(posedge i_sys_clk) disable iff (1'b0)
        i_reset |=> (&o_clk_oe_n) && !o_axil.bvalid && !o_axil.rvalid) else $error("outputs live after reset");
    chk_pin_hiz: assert property (
        !i_sync_request_n [*4] |=> &o_clk_oe_n) else $error("outputs driven during sync");
    chk_div_held: assert property (
        !i_sync_request_n [*4] |=> o_clk_out[3:0] == 4'h0 && o_clk_out[7:6] == 2'h0) else $error("divider ran in sync");
    chk_release_gap: assert property (
        !i_sync_request_n [*4] ##1 i_sync_request_n |-> (&o_clk_oe_n) [*4]) else $error("outputs on too early");
    chk_read_turn: assert property (
        i_axil.arvalid && o_axil.arready |=> o_axil.rvalid) else $error("read answer late");
    chk_read_hold: assert property (
        o_axil.rvalid && !i_axil.rready |=> o_axil.rvalid && $stable(o_axil.rdata)) else $error("read data dropped");
    chk_write_hold: assert property (
        o_axil.bvalid && !i_axil.bready |=> o_axil.bvalid && $stable(o_axil.bresp)) else $error("write resp dropped");
    chk_ar_block: assert property (
        o_axil.rvalid |-> !o_axil.arready) else $error("read taken while busy");
    chk_aw_block: assert property (
        o_axil.bvalid |-> !o_axil.awready && !o_axil.wready) else $error("write taken while busy");
    cover property (!i_sync_request_n [*4] ##1 i_sync_request_n ##[1:20] !o_clk_oe_n[0]);
    cover property (i_axil.arvalid && o_axil.arready);
    cover property (o_axil.bvalid && i_axil.bready);
endmodule : clock_sync_properties
bind clock_output_sync_and_enable clock_sync_properties #(.NUM_OUT(NUM_OUT)) i_props (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_sync_request_n(i_sync_request_n),
    .i_primary_clk(i_primary_clk), .i_secondary_clk(i_secondary_clk), .i_axil(i_axil),
    .o_axil(o_axil), .o_clk_out(o_clk_out), .o_clk_oe_n(o_clk_oe_n));
`default_nettype wire

// ===== verif/sys_ctrl_model.sv
// Purpose: System controller model driving the sync pin and bypass clocks
// Assumes: Pin and clocks change just after the system clock edge
// Notes:   Input clocks are slow divided levels so they can be sampled
`default_nettype none
module sys_ctrl_model (
    input  wire logic i_sys_clk,        // System clock
    input  wire logic i_hold_sync,      // Bench asks for a sync
    output var logic  o_sync_request_n, // Sync pin, active low
    output var logic  o_primary_clk,    // Primary input clock
    output var logic  o_secondary_clk   // Secondary input clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_q = 3'h0;
    initial o_sync_request_n = 1'b1;
    // Different rates so a wrong source select shows up
    always @(posedge i_sys_clk) cnt_q <= cnt_q + 3'h1;
    always @(posedge i_sys_clk) o_sync_request_n <= !i_hold_sync;
    assign o_primary_clk   = cnt_q[1];
    assign o_secondary_clk = cnt_q[2];
endmodule : sys_ctrl_model
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench for the output sync and enable block
// Assumes: 200 MHz clock, bench is the register bus master
// Notes:   Each scenario judges its own outcome before returning
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    sys_clk = 1'b0;
    logic                    reset = 1'b1;
    logic                    hold_sync = 1'b0;
    logic                    sync_n, pri, sec;
    clk_sync_pkg::axil_req_s req = '0;
    clk_sync_pkg::axil_rsp_s rsp;
    logic [7:0]              clk_out, oe_n;
    int                      n_errors = 0;
    int                      n_tests = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    sys_ctrl_model i_ctrl (.i_sys_clk(sys_clk), .i_hold_sync(hold_sync), .o_sync_request_n(sync_n),
        .o_primary_clk(pri), .o_secondary_clk(sec));
    clock_output_sync_and_enable i_dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_sync_request_n(sync_n),
        .i_primary_clk(pri), .i_secondary_clk(sec), .i_axil(req), .o_axil(rsp), .o_clk_out(clk_out),
        .o_clk_oe_n(oe_n));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        {req.awvalid, req.wvalid, req.bready} <= 3'h7;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        for (int k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                @(posedge sys_clk);
                return;
            end
        end
        n_errors++;
        tally_and_finish();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        {req.arvalid, req.rready} <= 2'h3;
        req.araddr <= a;
        for (int k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                {d, r} = {rsp.rdata, rsp.rresp};
                req.rready <= 1'b0;
                @(posedge sys_clk);
                return;
            end
        end
        n_errors++;
        tally_and_finish();
    endtask : rd
    task automatic test_regs();
        logic [7:0]  a [5] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h30};
        logic [31:0] e [5] = '{32'hff, 32'h0303, 32'h20, 32'h1, 32'h0};
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 5; i++) begin
            rd(a[i], d, r);
            check("reset value", d, e[i]);
            check("read resp", r, (i == 4) ? clk_sync_pkg::RESP_SLVERR : clk_sync_pkg::RESP_OKAY);
        end
        wr(8'h30, 32'h5a, r);
        check("unmapped write resp", r, clk_sync_pkg::RESP_SLVERR);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_pin_sync();
        int c, first;
        logic [31:0] d;
        logic [1:0]  r;
        for (int rep = 0; rep < 2; rep++) begin
            hold_sync <= 1'b1;
            repeat (6) @(posedge sys_clk);
            check("oe_n in sync", oe_n, 32'hff);
            check("divided outs held", clk_out & 8'hcf, 32'h0);
            rd(clk_sync_pkg::STATUS_OFS, d, r);
            check("sync status", d[0], 1'b1);
            hold_sync <= 1'b0;
            for (c = 0; c < 40 && oe_n === 8'hff; c++) @(posedge sys_clk);
            if (c == 40) begin
                n_errors++;
                tally_and_finish();
            end
            check("all on together", oe_n, 32'h0);
            check("first edge high", clk_out, 32'hff);
            check("release delay in range", c >= 7 && c <= 16, 1'b1);
            if (rep == 0) first = c;
        end
        check("delay spread", c - first <= 4 && first - c <= 4, 1'b1);
        $display("test_pin_sync done");
    endtask : test_pin_sync
    task automatic test_soft_groups();
        logic [31:0] d;
        logic [1:0]  r;
        logic        torn = 1'b0;
        wr(clk_sync_pkg::CTRL_OFS, 32'h0, r);
        repeat (3) @(posedge sys_clk);
        check("soft sync hiz", oe_n, 32'hff);
        wr(clk_sync_pkg::PRESCALE_OFS, 32'h0501, r);
        wr(clk_sync_pkg::CTRL_OFS, 32'h20, r);
        for (int k = 0; k < 40; k++) begin
            @(posedge sys_clk);
            if ((oe_n & 8'h33) != 8'h33 && (oe_n & 8'h33) != 8'h0) torn = 1'b1;
            if ((oe_n & 8'hcc) != 8'hcc && (oe_n & 8'hcc) != 8'h0) torn = 1'b1;
        end
        check("group cohesion", torn, 1'b0);
        check("both groups on", oe_n, 32'h0);
        wr(clk_sync_pkg::PRESCALE_OFS, 32'h0303, r);
        $display("test_soft_groups done");
    endtask : test_soft_groups
    task automatic test_enables();
        logic [7:0] en = 8'h00;
        logic [1:0] r;
        wr(clk_sync_pkg::OUT_EN_OFS, 32'h0, r);
        check("all disabled", oe_n, 32'hff);
        for (int i = 7; i >= 0; i--) begin
            en[(i * 3) % 8] = 1'b1;
            wr(clk_sync_pkg::OUT_EN_OFS, {24'h0, en}, r);
            check("one more on", oe_n, {24'h0, ~en});
        end
        $display("test_enables done");
    endtask : test_enables
    task automatic test_bypass();
        logic [1:0] r;
        for (int s = 0; s < 2; s++) begin
            wr(clk_sync_pkg::CTRL_OFS, 32'h23 | (s << 2), r);
            for (int k = 0; k < 8; k++) begin
                @(negedge sys_clk);
                check("bypass level", clk_out[5:4], {2{s ? sec : pri}});
            end
        end
        wr(clk_sync_pkg::CTRL_OFS, 32'h20, r);
        $display("test_bypass done");
    endtask : test_bypass
    initial begin
        repeat (2) @(posedge sys_clk);
        check("oe_n in reset", oe_n, 32'hff);
        reset <= 1'b0;
        // One idle edge so the first request never meets the release edge
        @(posedge sys_clk);
        test_regs();
        test_pin_sync();
        test_soft_groups();
        test_enables();
        test_bypass();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire

// ===== verilog/clk_sync_pkg.sv
// Purpose: Constants and carriers for the output sync and enable block
// Assumes: 200 MHz system clock, AXI4-Lite register access
// Notes:   Register layout and timing counts live here only
`default_nettype none
package clk_sync_pkg;
    localparam int unsigned NUM_OUTPUTS    = 8;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned ODIV_W         = 10;
    localparam int unsigned PS_W           = 8;

    // Register byte addresses
    localparam logic [7:0] OUT_EN_OFS      = 8'h00;
    localparam logic [7:0] PRESCALE_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS      = 8'h08;
    localparam logic [7:0] CTRL_OFS        = 8'h0c;
    localparam logic [7:0] ODIV_BASE_OFS   = 8'h10;
    localparam logic [7:0] ODIV_LAST_OFS   = 8'h2c;

    // Field positions
    localparam int unsigned CTRL_BYP4_BIT  = 0;
    localparam int unsigned CTRL_BYP5_BIT  = 1;
    localparam int unsigned CTRL_BSRC_BIT  = 2;
    localparam int unsigned CTRL_SYNC_BIT  = 5;
    localparam int unsigned PS_A_LSB       = 0;
    localparam int unsigned PS_B_LSB       = 8;
    localparam int unsigned ST_SYNC_BIT    = 0;
    localparam int unsigned ST_REL_BIT     = 1;
    localparam int unsigned ST_RUNA_BIT    = 2;
    localparam int unsigned ST_RUNB_BIT    = 3;

    // Reset values
    localparam logic [7:0]  OUT_EN_RST     = 8'hff;
    localparam logic [7:0]  PS_DIV_RST     = 8'h03;
    localparam logic [9:0]  ODIV_RST       = 10'h001;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Sync release to first output edge
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned SYNC_DLY_MIN_NS = 15;
    localparam int unsigned SYNC_DLY_MAX_NS = 20;
    localparam int unsigned SYNC_DLY_MIN_CYC = (SYNC_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_DLY_MAX_CYC = SYNC_DLY_MAX_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axil_req_s;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } axil_rsp_s;
endpackage : clk_sync_pkg
`default_nettype wire

// ===== verilog/clock_output_sync_and_enable.sv
// Purpose: Output sync, prescaler retiming, per-output enables and bypass mux
// Assumes: Inputs synchronous to i_sys_clk except the sync pin; prescalers are tick enables
// Notes:   Each prescaler ticks once per (div+1) system clocks
// Notes on behaviour
// - A sync request comes from the active-low pin or from the software sync bit, and resets every divider.
// - While sync is asserted every output is high impedance and every output divider is held in reset.
// - On release the block latches the release, retimes it to the prescalers, then enables group A and group B each on its own prescaler tick.
// - The first output edge comes about 35 ns after the pin changes, plus the wait for the next prescaler tick (50 ns with reset divides).
// - For a fixed setup the release-to-output delay varies by at most one prescaler A cycle.
// - Devices released together stay within one clock cycle with equal prescalers, two otherwise.
// - Outputs 0, 1, 4, 5 restart on prescaler A, outputs 2, 3, 6, 7 on prescaler B.
// - With equal prescaler divides all eight outputs turn on in the same cycle.
// - Outputs 4 and 5 can each select the bypass input clock instead of their own divider.
// - Each output has its own software enable bit, so outputs can be turned on in any order.
`default_nettype none
module clock_output_sync_and_enable #(
    parameter int unsigned NUM_OUT = clk_sync_pkg::NUM_OUTPUTS
) (
    input  wire logic                   i_sys_clk,          // 200 MHz system clock
    input  wire logic                   i_reset,            // Synchronous reset, active high
    input  wire logic                   i_sync_request_n,   // Asynchronous sync pin, active low
    input  wire logic                   i_primary_clk,      // Primary input clock level for bypass
    input  wire logic                   i_secondary_clk,    // Secondary input clock level for bypass
    input  wire clk_sync_pkg::axil_req_s i_axil,            // AXI4-Lite request channels
    output var clk_sync_pkg::axil_rsp_s o_axil,             // AXI4-Lite response channels
    output logic [NUM_OUT-1:0]          o_clk_out,          // Output clock levels
    output logic [NUM_OUT-1:0]          o_clk_oe_n          // Output enable, low while driving
);
    localparam logic [7:0] GROUP_B = 8'hcc;

    typedef struct packed {
        logic                                          aw_have;
        logic [clk_sync_pkg::ADDR_W-1:0]               aw_addr;
        logic                                          w_have;
        logic [31:0]                                   w_data;
        logic [3:0]                                    w_strb;
        logic                                          bvalid;
        logic [1:0]                                    bresp;
        logic                                          rvalid;
        logic [31:0]                                   rdata;
        logic [1:0]                                    rresp;
        logic                                          soft_sync_n;
        logic                                          byp4;
        logic                                          byp5;
        logic                                          byp_src;
        logic [7:0]                                    out_en;
        logic [clk_sync_pkg::PS_W-1:0]                 psa_div;
        logic [clk_sync_pkg::PS_W-1:0]                 psb_div;
        logic [7:0][clk_sync_pkg::ODIV_W-1:0]          odiv;
        logic                                          pin_meta;
        logic                                          pin_sync;
        logic                                          released;
        logic [2:0]                                    dly;
        logic [clk_sync_pkg::PS_W-1:0]                 psa_cnt;
        logic [clk_sync_pkg::PS_W-1:0]                 psb_cnt;
        logic                                          run_a;
        logic                                          run_b;
        logic [7:0][clk_sync_pkg::ODIV_W-1:0]          ocnt;
        logic [7:0]                                    oclk;
    } state_s;

    state_s st_q;
    state_s st_d;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic        sync_active;
    logic        tick_a;
    logic        tick_b;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic [31:0] ps_word;

    always_comb begin
        // Pin is usable only after both synchroniser stages
        sync_active = !st_q.pin_sync || !st_q.soft_sync_n;
        // Compare with >= so a divide lowered mid-run cannot leave the counter past its wrap point
        tick_a      = (st_q.psa_cnt >= st_q.psa_div);
        tick_b      = (st_q.psb_cnt >= st_q.psb_div);
        status_word = '0;
        status_word[clk_sync_pkg::ST_SYNC_BIT] = sync_active;
        status_word[clk_sync_pkg::ST_REL_BIT]  = st_q.released;
        status_word[clk_sync_pkg::ST_RUNA_BIT] = st_q.run_a;
        status_word[clk_sync_pkg::ST_RUNB_BIT] = st_q.run_b;
        ctrl_word   = '0;
        ctrl_word[clk_sync_pkg::CTRL_SYNC_BIT] = st_q.soft_sync_n;
        ctrl_word[clk_sync_pkg::CTRL_BYP4_BIT] = st_q.byp4;
        ctrl_word[clk_sync_pkg::CTRL_BYP5_BIT] = st_q.byp5;
        ctrl_word[clk_sync_pkg::CTRL_BSRC_BIT] = st_q.byp_src;
        ps_word     = '0;
        ps_word[clk_sync_pkg::PS_A_LSB +: clk_sync_pkg::PS_W] = st_q.psa_div;
        ps_word[clk_sync_pkg::PS_B_LSB +: clk_sync_pkg::PS_W] = st_q.psb_div;
    end

    always_comb begin
        logic [31:0] wv;
        logic [2:0]  oidx;
        wv   = '0;
        oidx = '0;
        st_d = st_q;

        st_d.pin_meta = i_sync_request_n;
        st_d.pin_sync = st_q.pin_meta;

        // Write path: address and data taken in either order
        if (i_axil.awvalid && !st_q.aw_have && !st_q.bvalid) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = i_axil.awaddr;
        end
        if (i_axil.wvalid && !st_q.w_have && !st_q.bvalid) begin
            st_d.w_have = 1'b1;
            st_d.w_data = i_axil.wdata;
            st_d.w_strb = i_axil.wstrb;
        end
        if (st_q.bvalid && i_axil.bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_have && st_q.w_have) begin
            st_d.aw_have = 1'b0;
            st_d.w_have  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = clk_sync_pkg::RESP_OKAY;
            oidx         = st_q.aw_addr[4:2];
            if (st_q.aw_addr == clk_sync_pkg::OUT_EN_OFS) begin
                wv = merge({24'h000000, st_q.out_en}, st_q.w_data, st_q.w_strb);
                st_d.out_en = wv[7:0];
            end else if (st_q.aw_addr == clk_sync_pkg::PRESCALE_OFS) begin
                wv = merge(ps_word, st_q.w_data, st_q.w_strb);
                st_d.psa_div = wv[clk_sync_pkg::PS_A_LSB +: clk_sync_pkg::PS_W];
                st_d.psb_div = wv[clk_sync_pkg::PS_B_LSB +: clk_sync_pkg::PS_W];
            end else if (st_q.aw_addr == clk_sync_pkg::CTRL_OFS) begin
                wv = merge(ctrl_word, st_q.w_data, st_q.w_strb);
                st_d.soft_sync_n = wv[clk_sync_pkg::CTRL_SYNC_BIT];
                st_d.byp4        = wv[clk_sync_pkg::CTRL_BYP4_BIT];
                st_d.byp5        = wv[clk_sync_pkg::CTRL_BYP5_BIT];
                st_d.byp_src     = wv[clk_sync_pkg::CTRL_BSRC_BIT];
            end else if (st_q.aw_addr == clk_sync_pkg::STATUS_OFS) begin
                st_d.bresp = clk_sync_pkg::RESP_OKAY;
            end else if (st_q.aw_addr >= clk_sync_pkg::ODIV_BASE_OFS && st_q.aw_addr <= clk_sync_pkg::ODIV_LAST_OFS
                         && st_q.aw_addr[1:0] == 2'h0) begin
                wv = merge({22'h000000, st_q.odiv[oidx]}, st_q.w_data, st_q.w_strb);
                st_d.odiv[oidx] = wv[clk_sync_pkg::ODIV_W-1:0];
            end else begin
                st_d.bresp = clk_sync_pkg::RESP_SLVERR;
            end
        end

        // Read path
        if (st_q.rvalid && i_axil.rready) begin
            st_d.rvalid = 1'b0;
        end
        if (i_axil.arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = clk_sync_pkg::RESP_OKAY;
            st_d.rdata  = '0;
            if (i_axil.araddr == clk_sync_pkg::OUT_EN_OFS) begin
                st_d.rdata = {24'h000000, st_q.out_en};
            end else if (i_axil.araddr == clk_sync_pkg::PRESCALE_OFS) begin
                st_d.rdata = ps_word;
            end else if (i_axil.araddr == clk_sync_pkg::STATUS_OFS) begin
                st_d.rdata = status_word;
            end else if (i_axil.araddr == clk_sync_pkg::CTRL_OFS) begin
                st_d.rdata = ctrl_word;
            end else if (i_axil.araddr >= clk_sync_pkg::ODIV_BASE_OFS && i_axil.araddr <= clk_sync_pkg::ODIV_LAST_OFS
                         && i_axil.araddr[1:0] == 2'h0) begin
                st_d.rdata = {22'h000000, st_q.odiv[i_axil.araddr[4:2]]};
            end else begin
                st_d.rresp = clk_sync_pkg::RESP_SLVERR;
            end
        end

        // Sync sequencing; prescalers restart from zero so equal divides tick together
        if (sync_active) begin
            st_d.released = 1'b0;
            st_d.dly      = '0;
            st_d.psa_cnt  = '0;
            st_d.psb_cnt  = '0;
            st_d.run_a    = 1'b0;
            st_d.run_b    = 1'b0;
            st_d.ocnt     = '0;
            st_d.oclk     = '0;
        end else begin
            st_d.released = 1'b1;
            st_d.psa_cnt  = tick_a ? '0 : st_q.psa_cnt + 1'b1;
            st_d.psb_cnt  = tick_b ? '0 : st_q.psb_cnt + 1'b1;
            if (st_q.released && st_q.dly < 3'(clk_sync_pkg::SYNC_DLY_MIN_CYC)) begin
                st_d.dly = st_q.dly + 3'h1;
            end
            // Restart only on a prescaler tick: jitter bounded to one prescaler cycle
            if (st_q.dly == 3'(clk_sync_pkg::SYNC_DLY_MIN_CYC)) begin
                if (tick_a && !st_q.run_a) begin
                    st_d.run_a = 1'b1;
                end
                if (tick_b && !st_q.run_b) begin
                    st_d.run_b = 1'b1;
                end
            end
            for (int i = 0; i < 8; i++) begin
                if (GROUP_B[i] ? (tick_b && !st_q.run_b && st_q.dly == 3'(clk_sync_pkg::SYNC_DLY_MIN_CYC))
                               : (tick_a && !st_q.run_a && st_q.dly == 3'(clk_sync_pkg::SYNC_DLY_MIN_CYC))) begin
                    st_d.oclk[i] = 1'b1;
                    st_d.ocnt[i] = '0;
                end else if (GROUP_B[i] ? (tick_b && st_q.run_b) : (tick_a && st_q.run_a)) begin
                    if (st_q.ocnt[i] >= st_q.odiv[i]) begin
                        st_d.ocnt[i] = '0;
                        st_d.oclk[i] = !st_q.oclk[i];
                    end else begin
                        st_d.ocnt[i] = st_q.ocnt[i] + 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            st_q             <= '0;
            st_q.soft_sync_n <= 1'b1;
            st_q.pin_meta    <= 1'b1;
            st_q.pin_sync    <= 1'b1;
            st_q.out_en      <= clk_sync_pkg::OUT_EN_RST;
            st_q.psa_div     <= clk_sync_pkg::PS_DIV_RST;
            st_q.psb_div     <= clk_sync_pkg::PS_DIV_RST;
            st_q.odiv        <= {8{clk_sync_pkg::ODIV_RST}};
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        o_axil.awready = !st_q.aw_have && !st_q.bvalid;
        o_axil.wready  = !st_q.w_have && !st_q.bvalid;
        o_axil.bvalid  = st_q.bvalid;
        o_axil.bresp   = st_q.bresp;
        o_axil.arready = !st_q.rvalid;
        o_axil.rvalid  = st_q.rvalid;
        o_axil.rdata   = st_q.rdata;
        o_axil.rresp   = st_q.rresp;
        for (int i = 0; i < NUM_OUT; i++) begin
            o_clk_out[i]  = st_q.oclk[i];
            o_clk_oe_n[i] = !((GROUP_B[i] ? st_q.run_b : st_q.run_a) && st_q.out_en[i]);
        end
        // Bypass feeds the input clock straight through; still gated by sync and enable
        if (st_q.byp4) begin
            o_clk_out[4] = st_q.byp_src ? i_secondary_clk : i_primary_clk;
        end
        if (st_q.byp5) begin
            o_clk_out[5] = st_q.byp_src ? i_secondary_clk : i_primary_clk;
        end
    end
endmodule : clock_output_sync_and_enable
`default_nettype wire
